// ### pkg/power_mode_consts.vh
// Constants for the power-saving mode controller.
// Operation
// R1: Slow-down runs all logic at one eighth of the normal rate.
// R2: Idle gates the CPU clock; peripherals keep running.
// R3: Power-down halts everything and stops the oscillator; RAM kept.
// R4: Modes entered only by software writes to register at 87h.
// R5: Block pin high makes entry sequences have no effect.
// R6: Block pin low lets software activate any mode.
// R7: Unconnected block pin reads high, blocking modes by default.
// R8: Block pin may change anytime; watchdog logic is unaffected.
// R9: Power-down needs arm-only write then trigger write on next instruction.
// R10: Power-down arm and trigger bits clear themselves after being set.
// R11: Trigger write is last instruction; only hardware reset leaves power-down.
// R12: Idle needs idle arm then idle trigger on consecutive instructions.
// R13: Any enabled interrupt ends idle; execution resumes after trigger.
// R14: Hardware reset ends idle; two machine cycles of reset suffice.
// R15: Strobes held high in idle, driven low in power-down.
// R16: External code: port 0 floats; port 2 address in idle, data otherwise.
// R17: Idle keeps port levels from entry; active alternate functions keep driving.
// R18: Unarmed trigger ignored; arm lapses after one intervening instruction.
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH
`define PCR_ADDR        8'h87
`define PCR_RESET       8'h00
`define PCR_IDLE_TRIG   0
`define PCR_IDLE_ARM    5
`define PCR_PD_TRIG     1
`define PCR_PD_ARM      6
`define PCR_SLOW        4
`define PCR_SMOD        7
`define SLOW_DIV        3'h7
`endif

// ### hw/slow_clock_div.v
// Divide-by-eight enable generator for slow-down mode.
`default_nettype none
`include "power_mode_consts.vh"
module slow_clock_div (
  input  wire       CLK_I,
  input  wire       RST_I,
  input  wire       slow_i,
  output wire       tick_o
);
  reg [2:0] cnt_r;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_r <= 3'h0;
    end else if (!slow_i) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // One tick in eight keeps the whole chip at an eighth of normal rate. R1
  assign tick_o = !slow_i || (cnt_r == `SLOW_DIV);
endmodule
`default_nettype wire

// ### hw/power_mode_ctrl.v
// Power-saving mode controller with control register and pin conditioning.
`default_nettype none
`include "power_mode_consts.vh"
module power_mode_ctrl (
  input  wire       CLK_I,
  input  wire       RST_I,
  input  wire       SFR_WR_I,
  input  wire [7:0] SFR_ADDR_I,
  input  wire [7:0] SFR_WDATA_I,
  input  wire       INSTR_DONE_I,
  input  wire       IRQ_ENABLED_I,
  input  wire       EXT_CODE_I,
  input  wire       BLOCK_PIN_I,
  input  wire       BLOCK_PIN_OE_N_I,
  input  wire       ALE_I,
  input  wire       PSS_I,
  input  wire [7:0] P0_O_I,
  input  wire       P0_OE_I,
  input  wire [7:0] P2_O_I,
  input  wire [7:0] P2_LATCH_I,
  input  wire [7:0] ALT_EN_I,
  input  wire [7:0] ALT_O_I,
  input  wire [7:0] P1_LATCH_I,
  output wire [7:0] PCR_RDATA_O,
  output wire       CPU_CLK_EN_O,
  output wire       PERIPH_CLK_EN_O,
  output wire       OSC_EN_O,
  output wire       IDLE_O,
  output wire       PDOWN_O,
  output wire       ALE_O,
  output wire       PSS_O,
  output wire [7:0] P0_O,
  output wire       P0_OE_O,
  output wire [7:0] P2_O,
  output wire [7:0] P1_O
);
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [7:0] pcr_r;
  reg        pd_armed_r;
  reg        idle_armed_r;
  reg        ext_r;
  reg  [7:0] p1_hold_r;
  reg  [7:0] p0_hold_r;
  reg  [7:0] p2_hold_r;
  reg        p0_oe_hold_r;
  wire       tick;
  wire       allowed;
  wire       pcr_wr;
  wire       pd_go;
  wire       idle_go;

  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_IDLE  = 3'h2;
  localparam [2:0] ST_PDOWN = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // A floating pin reads high, so modes stay blocked by default. R7
  assign allowed = !(BLOCK_PIN_I || BLOCK_PIN_OE_N_I); // R5 R6 R8
  assign pcr_wr  = SFR_WR_I && (SFR_ADDR_I == `PCR_ADDR) && (state_r == ST_RUN); // R4
  // Trigger counts only if the previous instruction armed it. R9 R12 R18
  assign pd_go   = pcr_wr && allowed && pd_armed_r && SFR_WDATA_I[`PCR_PD_TRIG];
  assign idle_go = pcr_wr && allowed && idle_armed_r && SFR_WDATA_I[`PCR_IDLE_TRIG];

  slow_clock_div u_div (
    .CLK_I  (CLK_I),
    .RST_I  (RST_I),
    .slow_i (pcr_r[`PCR_SLOW] && allowed),
    .tick_o (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (pd_go) begin
          state_nxt = ST_PDOWN; // R3 R11
        end else if (idle_go) begin
          state_nxt = ST_IDLE; // R2
        end
      end
      ST_IDLE: begin
        if (IRQ_ENABLED_I) begin
          state_nxt = ST_RUN; // R13
        end
      end
      // Only the asynchronous reset leaves power-down. R11
      ST_PDOWN: state_nxt = ST_PDOWN;
      default:  state_nxt = ST_RUN;
    endcase
  end

  // Reset acts at once, so two machine cycles of reset end idle fully. R14
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r      <= ST_RUN;
      pcr_r        <= `PCR_RESET;
      pd_armed_r   <= 1'b0;
      idle_armed_r <= 1'b0;
      ext_r        <= 1'b0;
      p1_hold_r    <= 8'h00;
      p0_hold_r    <= 8'h00;
      p2_hold_r    <= 8'h00;
      p0_oe_hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (pcr_wr) begin
        // Arm and trigger bits are never stored; they read back as zero. R10
        pcr_r <= SFR_WDATA_I & 8'h90;
        pd_armed_r   <= allowed && SFR_WDATA_I[`PCR_PD_ARM]
                        && !SFR_WDATA_I[`PCR_PD_TRIG]; // R9
        idle_armed_r <= allowed && SFR_WDATA_I[`PCR_IDLE_ARM]
                        && !SFR_WDATA_I[`PCR_IDLE_TRIG]; // R12
      end else if (INSTR_DONE_I) begin
        pd_armed_r   <= 1'b0; // R18
        idle_armed_r <= 1'b0; // R18
      end
      if (state_r == ST_RUN) begin
        ext_r        <= EXT_CODE_I;
        p1_hold_r    <= P1_LATCH_I;
        p0_hold_r    <= P0_O_I;
        p2_hold_r    <= P2_O_I;
        p0_oe_hold_r <= P0_OE_I;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign PCR_RDATA_O     = pcr_r;
  assign IDLE_O          = (state_r == ST_IDLE);
  assign PDOWN_O         = (state_r == ST_PDOWN);
  assign CPU_CLK_EN_O    = (state_r == ST_RUN) && tick; // R1 R2
  assign PERIPH_CLK_EN_O = !PDOWN_O && tick; // R1 R2 R3
  assign OSC_EN_O        = !PDOWN_O; // R3
  assign ALE_O = IDLE_O ? 1'b1 : (PDOWN_O ? 1'b0 : ALE_I); // R15
  assign PSS_O = IDLE_O ? 1'b1 : (PDOWN_O ? 1'b0 : PSS_I); // R15
  // External code floats port 0; port 2 keeps address in idle only. R16
  assign P0_OE_O = (state_r == ST_RUN) ? P0_OE_I : (!ext_r && p0_oe_hold_r);
  assign P0_O    = (state_r == ST_RUN) ? P0_O_I : p0_hold_r;
  assign P2_O    = (state_r == ST_RUN) ? P2_O_I :
                   ((IDLE_O && ext_r) ? p2_hold_r : P2_LATCH_I);

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_p1
      // Alternate functions keep driving in idle; plain pins hold entry level. R17
      assign P1_O[i] = (state_r == ST_RUN) ? P1_LATCH_I[i] :
                       ((IDLE_O && ALT_EN_I[i]) ? ALT_O_I[i] : p1_hold_r[i]);
    end
  endgenerate
endmodule
`default_nettype wire

// ### verif/pm_chk_chk.sv
// Port checker for the power mode controller.
`default_nettype none
module pm_chk (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       SFR_WR_I,
  input wire logic       INSTR_DONE_I,
  input wire logic       IRQ_ENABLED_I,
  input wire logic       BLOCK_PIN_I,
  input wire logic       BLOCK_PIN_OE_N_I,
  input wire logic       CPU_CLK_EN_O,
  input wire logic       OSC_EN_O,
  input wire logic       IDLE_O,
  input wire logic       PDOWN_O,
  input wire logic       ALE_O,
  input wire logic       PSS_O,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I
);
  timeunit 1ns;
  timeprecision 1ps;
  wire wr = SFR_WR_I && SFR_ADDR_I == 8'h87;
  wire en = !BLOCK_PIN_I && !BLOCK_PIN_OE_N_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  AST_PD_ENTER: assert property (en && wr && SFR_WDATA_I == 8'h40 ##1
    en && wr && SFR_WDATA_I == 8'h02 |=> PDOWN_O) else $error("pd missed");
  AST_PD_STAY: assert property (PDOWN_O |=> PDOWN_O) else $error("pd left");
  AST_PD_PINS: assert property (PDOWN_O |-> !OSC_EN_O && !ALE_O && !PSS_O)
    else $error("pd pins");
  AST_IDLE_PINS: assert property (IDLE_O |-> ALE_O && PSS_O && !CPU_CLK_EN_O)
    else $error("idle pins");
  AST_ENTRY_SRC: assert property ($rose(IDLE_O) || $rose(PDOWN_O) |->
    $past(wr && en)) else $error("entry src");
  AST_IDLE_SRC: assert property ($rose(IDLE_O) |-> $past(SFR_WDATA_I[0]))
    else $error("idle src");
  AST_IDLE_EXIT: assert property (IDLE_O && IRQ_ENABLED_I |-> ##[1:2] !IDLE_O)
    else $error("idle stuck");
  AST_LAPSE: assert property (wr && SFR_WDATA_I == 8'h40 ##1 INSTR_DONE_I ##1
    wr && SFR_WDATA_I == 8'h02 |=> !PDOWN_O) else $error("stale arm");
  cover property ($rose(PDOWN_O));
  cover property ($rose(IDLE_O));
  cover property ($fell(IDLE_O));
endmodule
`default_nettype wire

// ### verif/cpu_model.sv
// CPU core model that issues control register writes.
`default_nettype none
module cpu_model (
  input  wire logic       clk_i,
  output var  logic       wr_o   = 1'b0,
  output var  logic       done_o = 1'b0,
  output var  logic [7:0] addr_o = 8'h00,
  output var  logic [7:0] data_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines are inverted so a stale value never looks like a fresh write.
  task automatic op(input logic w, input logic [7:0] a, d, input logic dn);
    @(negedge clk_i);
    wr_o = w;
    done_o = dn;
    addr_o = w ? a : ~addr_o;
    data_o = w ? d : ~data_o;
  endtask
endmodule
`default_nettype wire

// ### verif/test_power_saving_mode_control.sv
// Self-checking bench for the power mode controller.
`default_nettype none
module test_power_saving_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic       CLK_I = 0, RST_I = 1, IRQ_ENABLED_I = 0, EXT_CODE_I = 0, P0_OE_I = 1;
  logic       BLOCK_PIN_I = 1, BLOCK_PIN_OE_N_I = 0, ALE_I = 1, PSS_I = 0;
  logic [7:0] P0_O_I = 8'h5a, P2_O_I = 8'h3c, P2_LATCH_I = 8'h96, ALT_EN_I = 8'h0f;
  logic [7:0] ALT_O_I = 8'hc3, P1_LATCH_I = 8'h69;
  wire        SFR_WR_I, INSTR_DONE_I, CPU_CLK_EN_O, PERIPH_CLK_EN_O, OSC_EN_O;
  wire        IDLE_O, PDOWN_O, ALE_O, PSS_O, P0_OE_O;
  wire  [7:0] SFR_ADDR_I, SFR_WDATA_I, PCR_RDATA_O, P0_O, P2_O, P1_O;
  int         n_errors = 0, checks_done = 0, k = 0;
  always #4 CLK_I = ~CLK_I;
  power_mode_ctrl i_dut (.*);
  cpu_model i_cpu (.clk_i(CLK_I), .wr_o(SFR_WR_I), .done_o(INSTR_DONE_I),
    .addr_o(SFR_ADDR_I), .data_o(SFR_WDATA_I));
  task automatic cmp(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [2:0] e);
    cmp({5'h00, IDLE_O, PDOWN_O, OSC_EN_O}, {5'h00, e});
  endtask
  task automatic seq(input logic [7:0] a, d1, d2);
    i_cpu.op(1'b1, a, d1, 1'b0);
    i_cpu.op(1'b1, a, d2, 1'b0);
    i_cpu.op(1'b0, a, d2, 1'b0);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge CLK_I);
    RST_I = 0;
    st(3'b001);
    cmp(PCR_RDATA_O, 8'h00);
    BLOCK_PIN_OE_N_I = 1;
    BLOCK_PIN_I = 0;
    seq(8'h87, 8'h20, 8'h01);
    st(3'b001);
    BLOCK_PIN_OE_N_I = 0;
    BLOCK_PIN_I = 1;
    seq(8'h87, 8'h40, 8'h02);
    st(3'b001);
    BLOCK_PIN_I = 0;
    seq(8'h88, 8'h20, 8'h01);
    st(3'b001);
    i_cpu.op(1'b1, 8'h87, 8'h40, 1'b0);
    i_cpu.op(1'b0, 8'h87, 8'h00, 1'b1);
    seq(8'h87, 8'h02, 8'h00);
    st(3'b001);
    // A low strobe input proves that idle forces the strobe high.
    ALE_I = 1'b0;
    seq(8'h87, 8'h20, 8'h01);
    st(3'b101);
    cmp({4'h0, ALE_O, PSS_O, CPU_CLK_EN_O, PERIPH_CLK_EN_O}, 8'h0d);
    P1_LATCH_I = 8'h00;
    ALT_O_I    = 8'h3c;
    P0_O_I     = 8'h00;
    P0_OE_I    = 1'b0;
    @(negedge CLK_I);
    cmp(P1_O, 8'h6c);
    cmp(P0_O, 8'h5a);
    cmp({7'h00, P0_OE_O}, 8'h01);
    cmp(P2_O, 8'h96);
    P0_OE_I = 1'b1;
    IRQ_ENABLED_I = 1;
    repeat (2) @(negedge CLK_I);
    IRQ_ENABLED_I = 0;
    st(3'b001);
    cmp(P1_O, 8'h00);
    seq(8'h87, 8'h10, 8'h10);
    cmp(PCR_RDATA_O, 8'h10);
    repeat (16) begin
      @(negedge CLK_I);
      k += CPU_CLK_EN_O + PERIPH_CLK_EN_O;
    end
    cmp(k[7:0], 8'h04);
    seq(8'h87, 8'h42, 8'h02);
    st(3'b001);
    EXT_CODE_I = 1;
    ALE_I = 1'b1;
    PSS_I = 1'b1;
    seq(8'h87, 8'h40, 8'h02);
    st(3'b010);
    cmp({5'h00, ALE_O, PSS_O, P0_OE_O}, 8'h00);
    cmp(P2_O, 8'h96);
    cmp(PCR_RDATA_O, 8'h00);
    IRQ_ENABLED_I = 1;
    repeat (2) @(negedge CLK_I);
    st(3'b010);
    RST_I = 1;
    @(negedge CLK_I);
    RST_I = 0;
    st(3'b001);
    IRQ_ENABLED_I = 0;
    cmp({6'h00, ALE_O, PSS_O}, 8'h03);
    seq(8'h87, 8'h20, 8'h01);
    P2_O_I = 8'h00;
    @(negedge CLK_I);
    st(3'b101);
    cmp(P2_O, 8'h3c);
    cmp({7'h00, P0_OE_O}, 8'h00);
    RST_I = 1;
    repeat (2) @(negedge CLK_I);
    RST_I = 0;
    st(3'b001);
    print_verdict();
  end
endmodule
bind power_mode_ctrl pm_chk i_chk (.*);
`default_nettype wire
